// ### inc/cscpkg.sv
package cscpkg;

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
localparam logic [3:0] REG_CTRL = 4'h0;
localparam logic [3:0] REG_STATUS = 4'h4;
localparam logic [3:0] REG_INPUTS = 4'h8;
localparam logic [3:0] REG_ALARM = 4'hc;

// ----------------------------------------------------------------
// Control register fields (CTRL_START, CTRL_CLEAR, CTRL_FULL_RESET write one to act; CTRL_GPIO3_CAL is held)
// ----------------------------------------------------------------
localparam int CTRL_START = 0;
localparam int CTRL_CLEAR = 1;
localparam int CTRL_FULL_RESET = 2;
localparam int CTRL_GPIO3_CAL = 3;

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
localparam int ST_ACTIVE = 0;
localparam int ST_DONE = 1;
localparam int ST_FAULT = 2;
localparam int ST_ALARM_BLK = 3;
localparam int ST_CHARGE_BLK = 4;
localparam int ST_CHARGING = 5;
localparam int ST_BACKUP = 6;
localparam int ST_SHUTDOWN = 7;
localparam int ST_REG_RESET = 8;
localparam int ST_FIELD_W = 12;

// ----------------------------------------------------------------
// Alarm message bits that abort calibration
// ----------------------------------------------------------------
localparam logic [15:0] ALARM_CAL_MASK = 16'h5800;

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
localparam logic GPIO3_CAL_RST = 1'b0;
localparam logic [31:0] READ_ZERO = 32'h0000_0000;

// ----------------------------------------------------------------
// Mode machine
// ----------------------------------------------------------------
typedef enum logic [5:0] {
    CSC_IDLE = 6'h01,
    CSC_CAL = 6'h02,
    CSC_CHARGE = 6'h04,
    CSC_BACKUP = 6'h08,
    CSC_HOLD = 6'h10,
    CSC_SHUTDOWN_INPUT = 6'h20
} csc_mode_t;

endpackage

// ### test/csc_host.sv
// ----------------------------------------------------------------
// Host model: classic Wishbone master, one cycle at a time
// ----------------------------------------------------------------
module csc_host (
    input wire logic clk_i,
    input wire logic ack_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 4'h0;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // Request held until ack is sampled, then released for a cycle
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// ### test/tb_csc_top.sv
module tb_csc_top
    import cscpkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] s_act = 32'h1 << ST_ACTIVE;
    localparam logic [31:0] s_done = 32'h1 << ST_DONE;
    localparam logic [31:0] s_flt = 32'h1 << ST_FAULT;
    localparam logic [31:0] s_ab = 32'h1 << ST_ALARM_BLK;
    localparam logic [31:0] s_chg = 32'h1 << ST_CHARGING;
    localparam logic [31:0] s_bk = 32'h1 << ST_BACKUP;
    localparam logic [31:0] s_rr = 32'h1 << ST_REG_RESET;
    logic clk_i, rst_i, cyc, stb, we, ack_o;
    logic [3:0] adr, sel;
    logic [31:0] wdat, dat_o, m, v;
    logic [11:0] pin;
    logic dis_en, ctype, iso, cgate, dgate, sp_oe_n, cd_oe_n, smb, osc;
    logic cen, bken, tclr;
    logic [31:0] exp_m[$];
    logic [31:0] exp_v[$];
    int fails = 0;
    int cmp_count = 0;
    csc_host i_csc_host (.clk_i(clk_i), .ack_i(ack_o), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    csc_top i_csc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(dat_o), .ack_o(ack_o), .shutdown_input_i(pin[11]),
        .supply_present_input_i(pin[10]), .undervoltage_detect_i(pin[9]),
        .back_drive_detect_i(pin[8]), .supply_overvoltage_detect_i(pin[7]),
        .discharge_cutoff_i(pin[6]), .thermistor_overrange_i(pin[5]),
        .thermistor_too_warm_i(pin[4]), .thermistor_underrange_i(pin[3]),
        .battery_retained_i(pin[2]), .chemistry_select_i(pin[1]),
        .host_mode_select_i(pin[0]), .discharge_enable_o(dis_en),
        .charge_enable_o(cen), .backup_enable_o(bken), .timer_clear_o(tclr),
        .charge_type_o(ctype), .battery_isolation_gate_o(iso),
        .charge_switch_gate_o(cgate), .discharge_switch_gate_o(dgate),
        .supply_present_status_out_o(),
        .supply_present_status_out_oe_n_o(sp_oe_n),
        .calibration_done_out_o(), .calibration_done_out_oe_n_o(cd_oe_n),
        .smbus_enable_o(smb), .osc_enable_o(osc));
    always #4 clk_i = ~clk_i;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        fails += exp_m.size();
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (5) @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_csc_host.bus(1'b1, a, d);
        settle();
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] mk,
                      input logic [31:0] vl);
        exp_m.push_back(mk);
        exp_v.push_back(vl);
        i_csc_host.bus(1'b0, a, 32'h0);
    endtask
    task automatic st(input logic [31:0] mk, input logic [31:0] vl);
        rd(REG_STATUS, mk, vl);
    endtask
    task automatic pchk(input logic got, input logic ex);
        cmp_count++;
        if (got !== ex) begin
            fails++;
            $display("mismatch at %0t: pin output %b", $time, got);
        end
    endtask
    // ----------------------------------------------------------------
    // Read checker: oldest note against each read answer
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0) begin
            cmp_count++;
            if (exp_m.size() == 0) begin
                fails++;
                $display("mismatch at %0t: read without note", $time);
            end else begin
                m = exp_m.pop_front();
                v = exp_v.pop_front();
                if ((dat_o & m) !== v) begin
                    fails++;
                    $display("mismatch at %0t: read %h", $time, dat_o);
                end
            end
        end
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        int seed, k, idx[4];
        logic [31:0] al, ev;
        idx = '{8, 7, 4, 5};
        clk_i = 1'b0;
        rst_i = 1'b1;
        pin = 12'h404;
        seed = $urandom(53);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        pin[1:0] <= 2'($urandom_range(3));
        rd(4'h6, 32'hffffffff, 32'h0);
        wr(REG_CTRL, 32'h9);
        st(s_act | s_done | s_flt, s_act);
        pchk(dis_en, 1'b1);
        pchk(dgate, 1'b1);
        pin[6] <= 1'b1;
        settle();
        st(s_act | s_done | s_chg, s_done | s_chg);
        pchk(ctype, pin[1] ^ pin[0]);
        pchk(cen, 1'b1);
        pchk(cd_oe_n, 1'b0);
        pin[6] <= 1'b0;
        wr(REG_CTRL, 32'h2);
        st(s_act | s_done | s_flt, 32'h0);
        pchk(cd_oe_n, 1'b1);
        for (int i = 0; i < 5; i++) begin
            wr(REG_CTRL, 32'h1);
            st(s_act | s_done | s_flt | s_chg, s_act);
            if (i < 4) begin
                pin[idx[i]] <= 1'b1;
                settle();
            end else begin
                al = $urandom() & 32'hffff & ~{16'h0, ALARM_CAL_MASK};
                wr(REG_ALARM, al);
                st(s_act | s_flt, s_act);
                k = $urandom_range(2);
                wr(REG_ALARM, al | (32'h1 << (k == 2 ? 14 : 11 + k)));
            end
            ev = (i == 4) ? s_flt | s_ab : s_flt;
            st(s_act | s_flt | s_ab, ev);
            wr(REG_CTRL, 32'h1);
            st(s_act | s_flt, s_flt);
            pin[idx[i % 4]] <= 1'b0;
            settle();
            st(s_act | s_flt | s_chg, s_flt | s_chg);
            wr(REG_CTRL, 32'h2);
            st(s_act | s_flt, 32'h0);
        end
        wr(REG_CTRL, 32'h1);
        wr(REG_CTRL, 32'h4);
        st(s_act | s_flt | s_ab, 32'h0);
        wr(REG_CTRL, 32'h1);
        pin[10] <= 1'b0;
        settle();
        st(s_act | s_flt | s_bk | s_ab, s_flt | s_bk);
        pin[10] <= 1'b1;
        settle();
        st(s_flt, s_flt);
        pin[11] <= 1'b1;
        settle();
        st(s_flt | s_rr, s_rr);
        pchk(sp_oe_n, 1'b0);
        pchk(tclr, 1'b1);
        wr(REG_CTRL, 32'h1);
        st(s_act, 32'h0);
        pin[10:9] <= 2'b01;
        settle();
        pchk(iso, 1'b1);
        pchk(cgate, 1'b0);
        pchk(dgate, 1'b0);
        pchk(smb, 1'b0);
        pchk(osc, 1'b0);
        pchk(sp_oe_n, 1'b1);
        pchk(tclr, 1'b1);
        pchk(bken, 1'b0);
        pin[11] <= 1'b0;
        settle();
        pchk(iso, 1'b1);
        pin[10:9] <= 2'b10;
        settle();
        pchk(iso, 1'b0);
        pchk(smb, 1'b1);
        complete_run();
    end
endmodule

// ### verilog/csc_sync.sv
module csc_sync
    import cscpkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule

// ### verilog/csc_top.sv
module csc_top
    import cscpkg::*;
#(
    parameter int TIMER_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic shutdown_input_i,
    input wire logic supply_present_input_i,
    input wire logic undervoltage_detect_i,
    input wire logic back_drive_detect_i,
    input wire logic supply_overvoltage_detect_i,
    input wire logic discharge_cutoff_i,
    input wire logic thermistor_overrange_i,
    input wire logic thermistor_too_warm_i,
    input wire logic thermistor_underrange_i,
    input wire logic battery_retained_i,
    input wire logic chemistry_select_i,
    input wire logic host_mode_select_i,
    output logic discharge_enable_o,
    output logic charge_enable_o,
    output logic backup_enable_o,
    output logic timer_clear_o,
    output logic charge_type_o,
    output logic battery_isolation_gate_o,
    output logic charge_switch_gate_o,
    output logic discharge_switch_gate_o,
    output logic supply_present_status_out_o,
    output logic supply_present_status_out_oe_n_o,
    output logic calibration_done_out_o,
    output logic calibration_done_out_oe_n_o,
    output logic smbus_enable_o,
    output logic osc_enable_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = 12;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s;
    logic shutdown_input, sup, uvd, back_drive_detect, ovp, cutoff, t_or, t_hot, t_ur;
    logic bat_ok, chem, hostsel;

    assign pin_raw = {shutdown_input_i, supply_present_input_i,
        undervoltage_detect_i, back_drive_detect_i,
        supply_overvoltage_detect_i, discharge_cutoff_i,
        thermistor_overrange_i, thermistor_too_warm_i,
        thermistor_underrange_i, battery_retained_i,
        chemistry_select_i, host_mode_select_i};

    csc_sync #(
        .W(NPIN)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    assign {shutdown_input, sup, uvd, back_drive_detect, ovp, cutoff, t_or, t_hot, t_ur,
        bat_ok, chem, hostsel} = pin_s;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic wr_ctrl, wr_alarm;
    logic [31:0] wdata;
    logic [31:0] status_word, inputs_word, alarm_word, ctrl_word;
    logic gpio3_cal;
    logic [15:0] alarm_msg;
    csc_mode_t mode, next_mode;
    logic cal_fault, cal_done, alarm_blk, charge_blk;

    // Register reset and shutdown block host writes; reads are still answered
    logic bus_block;
    assign bus_block = mode == CSC_HOLD || mode == CSC_SHUTDOWN_INPUT;

    csc_wb u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .status_i(status_word),
        .inputs_i(inputs_word),
        .alarm_i(alarm_word),
        .ctrl_rd_i(ctrl_word),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .wr_ctrl_o(wr_ctrl),
        .wr_alarm_o(wr_alarm),
        .wdata_o(wdata)
    );

    logic start_wr, clear_wr, full_wr;
    assign start_wr = wr_ctrl && !bus_block && wdata[CTRL_START];
    assign clear_wr = wr_ctrl && !bus_block && wdata[CTRL_CLEAR];
    assign full_wr = wr_ctrl && !bus_block && wdata[CTRL_FULL_RESET];

    // Alarm message from the battery, latched for readback
    logic alarm_hit;
    assign alarm_hit = wr_alarm && !bus_block
        && |(wdata[15:0] & ALARM_CAL_MASK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_msg <= '0;
        end else if (bus_block) begin
            alarm_msg <= '0;
        end else if (wr_alarm) begin
            alarm_msg <= wdata[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpio3_cal <= GPIO3_CAL_RST;
        end else if (bus_block) begin
            gpio3_cal <= GPIO3_CAL_RST;
        end else if (wr_ctrl) begin
            gpio3_cal <= wdata[CTRL_GPIO3_CAL];
        end
    end

    // ------------------------------------------------------------
    // Mode machine
    // ------------------------------------------------------------
    logic lost, start_ok, prot_trip, therm_bad, therm_good;
    logic cal_wait;
    assign lost = !sup || shutdown_input || uvd || full_wr;
    assign start_ok = !t_or && sup && !shutdown_input && !cal_fault
        && start_wr;
    assign prot_trip = back_drive_detect || ovp;
    assign therm_bad = (t_hot && !t_ur) || t_or;
    assign therm_good = !therm_bad;

    always_comb begin
        next_mode = mode;
        case (mode)
            CSC_SHUTDOWN_INPUT: begin
                if (!uvd) begin
                    next_mode = CSC_IDLE;
                end
            end
            default: begin
                if (uvd && shutdown_input) begin
                    next_mode = CSC_SHUTDOWN_INPUT;
                end else if (shutdown_input && sup) begin
                    next_mode = CSC_HOLD;
                end else if (mode == CSC_HOLD) begin
                    if (!shutdown_input) begin
                        next_mode = CSC_IDLE;
                    end
                end else if (!sup || uvd) begin
                    next_mode = CSC_BACKUP;
                end else if (mode == CSC_CAL) begin
                    if (full_wr || clear_wr) begin
                        next_mode = CSC_IDLE;
                    end else if (prot_trip || cutoff || alarm_hit) begin
                        next_mode = CSC_CHARGE;
                    end else if (therm_bad) begin
                        next_mode = CSC_IDLE;
                    end
                end else if (start_ok) begin
                    next_mode = CSC_CAL;
                end else if (mode == CSC_BACKUP) begin
                    next_mode = CSC_IDLE;
                end else if (mode == CSC_IDLE && cal_fault
                    && cal_wait && therm_good) begin
                    next_mode = CSC_CHARGE;
                end
            end
        endcase
    end

    // Thermal abort remembered until the thermistor recovers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_wait <= 1'b0;
        end else if (mode == CSC_CAL && next_mode == CSC_IDLE
            && therm_bad && !lost && !clear_wr) begin
            cal_wait <= 1'b1;
        end else if (next_mode != CSC_IDLE || clear_wr) begin
            cal_wait <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= CSC_IDLE;
        end else begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    logic fault_set, fault_clr;
    assign fault_set = mode == CSC_CAL && !clear_wr && !full_wr
        && !shutdown_input && (prot_trip || therm_bad || alarm_hit || !sup
        || uvd);
    // Supply loss alone keeps the fault while the battery holds
    assign fault_clr = clear_wr || full_wr || shutdown_input
        || (!bat_ok && !sup);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_fault <= 1'b0;
        end else if (fault_set) begin
            cal_fault <= 1'b1;
        end else if (fault_clr) begin
            cal_fault <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_done <= 1'b0;
        end else if (mode == CSC_CAL && cutoff && !lost && !clear_wr
            && !prot_trip && !alarm_hit) begin
            cal_done <= 1'b1;
        end else if (clear_wr || bus_block || full_wr
            || (start_ok && mode != CSC_CAL)) begin
            cal_done <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_blk <= 1'b0;
        end else if (lost || bus_block) begin
            alarm_blk <= 1'b0;
        end else if (mode == CSC_CAL && alarm_hit) begin
            alarm_blk <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            charge_blk <= 1'b0;
        end else if (lost || bus_block) begin
            charge_blk <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic in_shutdown_input;
    assign in_shutdown_input = mode == CSC_SHUTDOWN_INPUT;
    assign discharge_enable_o = mode == CSC_CAL;
    assign charge_enable_o = mode == CSC_CHARGE;
    assign backup_enable_o = mode == CSC_BACKUP;
    assign timer_clear_o = mode == CSC_HOLD || in_shutdown_input
        || (next_mode == CSC_CAL && mode != CSC_CAL);
    assign charge_type_o = chem ^ hostsel;
    assign battery_isolation_gate_o = in_shutdown_input;
    assign charge_switch_gate_o = mode == CSC_CHARGE;
    assign discharge_switch_gate_o = mode == CSC_CAL;
    assign supply_present_status_out_o = 1'b0;
    assign supply_present_status_out_oe_n_o = !(sup && !in_shutdown_input);
    assign calibration_done_out_o = 1'b0;
    assign calibration_done_out_oe_n_o = !(gpio3_cal && cal_done
        && !in_shutdown_input);
    assign smbus_enable_o = !in_shutdown_input;
    assign osc_enable_o = !in_shutdown_input;

    always_comb begin
        status_word = READ_ZERO;
        status_word[ST_ACTIVE] = mode == CSC_CAL;
        status_word[ST_DONE] = cal_done;
        status_word[ST_FAULT] = cal_fault;
        status_word[ST_ALARM_BLK] = alarm_blk;
        status_word[ST_CHARGE_BLK] = charge_blk;
        status_word[ST_CHARGING] = mode == CSC_CHARGE;
        status_word[ST_BACKUP] = mode == CSC_BACKUP;
        status_word[ST_SHUTDOWN] = in_shutdown_input;
        status_word[ST_REG_RESET] = mode == CSC_HOLD;
    end
    assign inputs_word = {{(32 - NPIN){1'b0}}, pin_s};
    assign alarm_word = {16'h0000, alarm_msg};
    assign ctrl_word = {28'h0000000, gpio3_cal, 3'h0};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    back_drive_detect_end_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        mode == CSC_CAL && back_drive_detect && sup && !uvd && !shutdown_input && !clear_wr
        && !full_wr |=> mode == CSC_CHARGE && cal_fault)
        else $error("back drive did not end calibration");
    ovp_end_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        mode == CSC_CAL && ovp && sup && !uvd && !shutdown_input && !clear_wr
        && !full_wr |=> !discharge_enable_o && charge_enable_o && cal_fault)
        else $error("overvoltage did not end calibration");
    loss_backup_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        mode == CSC_CAL && !sup && !shutdown_input && !full_wr && !clear_wr
        |=> backup_enable_o && cal_fault)
        else $error("supply loss did not enter backup");
    fault_block_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        cal_fault && mode != CSC_CAL |=> mode != CSC_CAL)
        else $error("calibration started with fault set");
    clear_flags_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        clear_wr && mode != CSC_CAL |=> !cal_fault && !cal_done)
        else $error("clear write left a flag set");
    shutdown_input_reset_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        shutdown_input && sup && !uvd && mode != CSC_SHUTDOWN_INPUT |=> mode == CSC_HOLD)
        else $error("shutdown did not reset registers");
    shutdown_input_gates_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        in_shutdown_input |-> battery_isolation_gate_o && !charge_switch_gate_o
        && !discharge_switch_gate_o && !smbus_enable_o)
        else $error("shutdown gates wrong");
    uv_return_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        in_shutdown_input && !uvd |=> mode == CSC_IDLE)
        else $error("shutdown not left on supply return");

endmodule

// ### verilog/csc_wb.sv
module csc_wb
    import cscpkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] status_i,
    input wire logic [31:0] inputs_i,
    input wire logic [31:0] alarm_i,
    input wire logic [31:0] ctrl_rd_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic wr_ctrl_o,
    output logic wr_alarm_o,
    output logic [31:0] wdata_o
);

    // ------------------------------------------------------------
    // One wait state: ack one cycle after the request, then drop
    // ------------------------------------------------------------
    logic req;
    assign req = cyc_i && stb_i && !ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= READ_ZERO;
        end else if (req && !we_i) begin
            case (adr_i)
                REG_CTRL: dat_o <= ctrl_rd_i;
                REG_STATUS: dat_o <= status_i;
                REG_INPUTS: dat_o <= inputs_i;
                REG_ALARM: dat_o <= alarm_i;
                default: dat_o <= READ_ZERO;
            endcase
        end
    end

    // Write strobes fire with ack, the edge the master takes it
    logic wr_go;
    assign wr_go = cyc_i && stb_i && ack_o && we_i;
    assign wr_ctrl_o = wr_go && sel_i[0] && adr_i == REG_CTRL;
    assign wr_alarm_o = wr_go && (&sel_i[1:0]) && adr_i == REG_ALARM;
    assign wdata_o = dat_i;

endmodule
